// File: design/ips_pkg.sv
// constants and types shared by the integer pipeline sequencer
package ips_pkg;
  localparam int          FETCH_BYTES = 16;
  localparam int          QUEUE_BYTES = 48;
  localparam int          MAX_ILEN    = 8;
  localparam int          NREG        = 8;
  localparam int          LSU_DEPTH   = 4;
  localparam logic [31:0] RESET_PC    = 32'h0000_0000;
  // first opcode byte: kind[7:6] float[5] cond[4] len-1[2:0]
  localparam int          FP_BIT      = 5;
  localparam int          COND_BIT    = 4;
  // micro-word fields
  localparam int          UW_WR       = 4;
  localparam int          UW_ST       = 3;

  typedef enum logic [1:0] {
    K_ALU    = 2'h0,
    K_LOAD   = 2'h1,
    K_STORE  = 2'h2,
    K_BRANCH = 2'h3
  } ips_kind_t;

  typedef enum logic [2:0] {
    ALU_ADD = 3'h0, ALU_SUB = 3'h1, ALU_AND = 3'h2,
    ALU_XOR = 3'h3, ALU_PB  = 3'h4, ALU_PA  = 3'h5
  } ips_alu_t;

  // indexed by {kind, fn}: {write reg, store, alu op}
  localparam logic [15:0][4:0] UCODE = {
    5'h00, 5'h00, 5'h00, 5'h00,
    5'h0D, 5'h0D, 5'h0D, 5'h0D,
    5'h14, 5'h14, 5'h14, 5'h14,
    5'h13, 5'h12, 5'h11, 5'h10
  };

  typedef enum logic [1:0] {
    LSU_IDLE  = 2'b00,
    LSU_READ  = 2'b01,
    LSU_WRITE = 2'b11
  } ips_lsu_st_t;

  typedef struct packed {
    logic        v;
    ips_kind_t   kind;
    logic        fp;
    logic [1:0]  fn;
    logic [2:0]  rd;
    logic [2:0]  rs;
    logic [3:0]  len;
    logic [31:0] pc;
    logic [31:0] raw;
    logic [31:0] disp;
    logic [31:0] addr;
    logic [31:0] a;
    logic [31:0] b;
  } ips_op_t;
endpackage

// File: design/ips_code_queue.sv
// byte queue between fetch and decode
`timescale 1ns/1ps
`default_nettype none
module ips_code_queue #(
  parameter int DEPTH = ips_pkg::QUEUE_BYTES,
  parameter int IN_B  = ips_pkg::FETCH_BYTES,
  parameter int OUT_B = ips_pkg::MAX_ILEN,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  // fill side
  input  wire logic                flush,
  input  wire logic                push_valid,
  input  wire logic [IN_B*8-1:0]   push_data,
  output logic                     push_ready,
  // drain side
  input  wire logic [3:0]          pop_len,
  output logic [OUT_B*8-1:0]       peek,
  output logic [CW-1:0]            count
);
  typedef struct packed {
    logic [DEPTH*8-1:0] mem;
    logic [CW-1:0]      cnt;
  } ips_cq_st_t;

  ips_cq_st_t st_q, st_d;

  // room judged before this cycle's pop: no path from decode into fetch
  assign push_ready = st_q.cnt <= CW'(DEPTH - IN_B);
  assign peek       = st_q.mem[OUT_B*8-1:0];
  assign count      = st_q.cnt;

  always_comb begin
    st_d = st_q;
    if (flush) begin
      st_d.cnt = '0;
    end else begin
      st_d.mem = st_q.mem >> (pop_len * 8);
      st_d.cnt = st_q.cnt - CW'(pop_len);
      if (push_valid && push_ready) begin
        st_d.mem[st_d.cnt*8 +: IN_B*8] = push_data;
        st_d.cnt = st_d.cnt + CW'(IN_B);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  AST_Q_BOUND: assert property (@(posedge clk_sys) disable iff (sys_rst)
    int'(st_q.cnt) <= DEPTH) else $error("code queue above capacity");
endmodule // ips_code_queue
`default_nettype wire

// File: design/ips_lsu.sv
// load/store unit: write buffer, read priority, read bypass
`timescale 1ns/1ps
`default_nettype none
module ips_lsu #(
  parameter int DEPTH = ips_pkg::LSU_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // stores from write-back
  input  wire logic        st_valid,
  input  wire logic [31:0] st_addr,
  input  wire logic [31:0] st_data,
  output logic             st_ready,
  // loads from the address stage
  input  wire logic        rd_req,
  input  wire logic [31:0] rd_addr,
  output logic             rd_ack,
  output logic [31:0]      rd_data,
  // memory side
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);
  typedef struct packed {
    ips_pkg::ips_lsu_st_t        st;
    logic [DEPTH-1:0][31:0]      wa;
    logic [DEPTH-1:0][31:0]      wd;
    logic [CW-1:0]               cnt;
    logic                        ack;
    logic [31:0]                 rdat;
    logic [31:0]                 ra;
  } ips_lsu_s_t;

  ips_lsu_s_t       s_q, s_d;
  logic [DEPTH-1:0] hit;
  logic [31:0]      byp;

  for (genvar i = 0; i < DEPTH; i++) begin : g_hit
    assign hit[i] = (CW'(i) < s_q.cnt) && (s_q.wa[i] == rd_addr);
  end

  // entry 0 oldest, so the last match is the youngest store
  always_comb begin
    byp = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (hit[i]) begin
        byp = s_q.wd[i];
      end
    end
  end

  always_comb begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    unique case (s_q.st)
      ips_pkg::LSU_IDLE: begin
        if (rd_req && !s_q.ack) begin
          if (|hit) begin
            s_d.ack  = 1'b1;
            s_d.rdat = byp;
          end else begin
            s_d.st = ips_pkg::LSU_READ;
            s_d.ra = rd_addr;
          end
        end else if (s_q.cnt != '0) begin
          s_d.st = ips_pkg::LSU_WRITE;
        end
      end
      ips_pkg::LSU_READ: begin
        if (mem_ack) begin
          s_d.st   = ips_pkg::LSU_IDLE;
          s_d.ack  = 1'b1;
          s_d.rdat = mem_rdata;
        end
      end
      ips_pkg::LSU_WRITE: begin
        if (mem_ack) begin
          s_d.st  = ips_pkg::LSU_IDLE;
          s_d.wa  = s_q.wa >> 32;
          s_d.wd  = s_q.wd >> 32;
          s_d.cnt = s_q.cnt - CW'(1);
        end
      end
      default: s_d.st = ips_pkg::LSU_IDLE;
    endcase
    if (st_valid && st_ready) begin
      s_d.wa[s_d.cnt] = st_addr;
      s_d.wd[s_d.cnt] = st_data;
      s_d.cnt         = s_d.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign st_ready  = s_q.cnt < CW'(DEPTH);
  assign rd_ack    = s_q.ack;
  assign rd_data   = s_q.rdat;
  assign mem_req   = s_q.st != ips_pkg::LSU_IDLE;
  assign mem_we    = s_q.st == ips_pkg::LSU_WRITE;
  assign mem_addr  = mem_we ? s_q.wa[0] : s_q.ra;
  assign mem_wdata = s_q.wd[0];

  AST_L_BYPASS: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_q.st == ips_pkg::LSU_IDLE && rd_req && !rd_ack && |hit |=> rd_ack && !mem_req)
    else $error("buffered load not bypassed");
  AST_L_READ_FIRST: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_q.st == ips_pkg::LSU_IDLE && rd_req && !rd_ack && !(|hit) && s_q.cnt != '0
    |=> mem_req && !mem_we) else $error("write issued ahead of load");
endmodule // ips_lsu
`default_nettype wire

// File: design/ips_seq.sv
// integer pipeline sequencer: fetch, decode, two address stages, execute, write-back
`timescale 1ns/1ps
`default_nettype none
module ips_seq #(
  parameter int FETCH_BYTES = ips_pkg::FETCH_BYTES,
  parameter int QUEUE_BYTES = ips_pkg::QUEUE_BYTES,
  parameter int LSU_DEPTH   = ips_pkg::LSU_DEPTH
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  // instruction cache
  output logic                          ic_req,
  output logic [31:0]                   ic_addr,
  input  wire logic                     ic_ack,
  input  wire logic [FETCH_BYTES*8-1:0] ic_data,
  // translation unit
  input  wire logic [31:0]              seg_base,
  input  wire logic [31:0]              xlat_base,
  input  wire logic [31:0]              mem_limit,
  output logic                          mm_fault,
  // float unit
  output logic                          fp_valid,
  input  wire logic                     fp_ready,
  output logic [63:0]                   fp_data,
  // external memory
  output logic                          mem_req,
  output logic                          mem_we,
  output logic [31:0]                   mem_addr,
  output logic [31:0]                   mem_wdata,
  input  wire logic                     mem_ack,
  input  wire logic [31:0]              mem_rdata
);
  localparam int CW = $clog2(QUEUE_BYTES + 1);

  typedef struct packed {
    logic [31:0]                        fpc;
    logic [31:0]                        dpc;
    ips_pkg::ips_op_t                   dc;
    ips_pkg::ips_op_t                   a1;
    ips_pkg::ips_op_t                   a2;
    ips_pkg::ips_op_t                   ex;
    logic [ips_pkg::NREG-1:0][31:0]     rf;
    logic                               fault;
    logic                               held;
    logic [31:0]                        hdat;
  } ips_top_st_t;

  ips_top_st_t      s_q, s_d;
  logic             q_ready;
  logic [63:0]      win;
  logic [CW-1:0]    qcnt;
  logic [3:0]       len;
  logic [3:0]       pop_len;
  logic [7:0]       b0, b1, b2;
  logic [31:0]      disp;
  logic [31:0]      target;
  logic             dec_ok;
  logic             taken;
  logic             adv;
  logic             wb_block;
  logic             a2_block;
  logic             wb_wr;
  logic             wb_st;
  logic             st_ready;
  logic             rd_req;
  logic             rd_ack;
  logic [31:0]      rd_data;
  logic             rd_have;
  logic [31:0]      rd_val;
  logic [31:0]      phys;
  logic             memop;
  logic             mem_rd;
  logic             fault;
  logic             haz;
  logic [31:0]      opnd;
  logic [4:0]       uw_ex;
  logic [31:0]      ex_res;
  ips_pkg::ips_op_t dcn, a1n, a2n, exn;

  // fetch: one line per cache answer, only while the queue has room
  assign ic_req  = q_ready;
  assign ic_addr = s_q.fpc;

  ips_code_queue #(
    .DEPTH (QUEUE_BYTES),
    .IN_B  (FETCH_BYTES),
    .OUT_B (ips_pkg::MAX_ILEN),
    .CW    (CW)
  ) u_queue (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .flush      (taken),
    .push_valid (ic_req && ic_ack),
    .push_data  (ic_data),
    .push_ready (q_ready),
    .pop_len    (pop_len),
    .peek       (win),
    .count      (qcnt)
  );

  // decode: length and kind from the head bytes
  assign b0  = win[7:0];
  assign b1  = win[15:8];
  assign b2  = win[23:16];
  assign len = {1'b0, b0[2:0]} + 4'h1;

  always_comb begin
    disp = '0;
    for (int k = 0; k < 4; k++) begin
      if (int'(len) > k + 2) begin
        disp[k*8 +: 8] = win[(k+2)*8 +: 8];
      end
    end
  end

  assign adv     = !wb_block && !a2_block;
  assign dec_ok  = adv && (qcnt >= CW'(len));
  assign pop_len = dec_ok ? len : 4'h0;
  assign target  = s_q.dpc + 32'(len) + {{24{b2[7]}}, b2};
  // backward conditional branches predicted taken, forward ones not
  assign taken   = dec_ok && b0[7:6] == ips_pkg::K_BRANCH
                   && (!b0[ips_pkg::COND_BIT] || b2[7]);

  always_comb begin
    dcn      = '0;
    // branches end at decode: their only effect is the redirect
    dcn.v    = dec_ok && b0[7:6] != ips_pkg::K_BRANCH;
    dcn.kind = ips_pkg::ips_kind_t'(b0[7:6]);
    dcn.fp   = b0[ips_pkg::FP_BIT];
    dcn.fn   = b1[7:6];
    dcn.rd   = b1[5:3];
    dcn.rs   = b1[2:0];
    dcn.len  = len;
    dcn.pc   = s_q.dpc;
    dcn.raw  = win[31:0];
    dcn.disp = disp;
  end

  // first address stage
  always_comb begin
    a1n      = s_q.dc;
    a1n.addr = seg_base + s_q.dc.disp;
  end

  // second address stage: translation, limit check, reads, float handoff
  function automatic logic writes(input ips_pkg::ips_op_t o);
    return o.v && ips_pkg::UCODE[{o.kind, o.fn}][ips_pkg::UW_WR];
  endfunction

  function automatic logic stores(input ips_pkg::ips_op_t o);
    return o.v && ips_pkg::UCODE[{o.kind, o.fn}][ips_pkg::UW_ST];
  endfunction

  // forwarding keeps register reads correct without interlock bubbles
  function automatic logic [31:0] fwd(input logic [2:0] r);
    if (writes(s_q.a2) && s_q.a2.rd == r) begin
      return ex_res;
    end else if (writes(s_q.ex) && s_q.ex.rd == r) begin
      return s_q.ex.a;
    end
    return s_q.rf[r];
  endfunction

  assign phys   = s_q.a1.addr + xlat_base;
  assign memop  = s_q.a1.v && (s_q.a1.kind == ips_pkg::K_LOAD
                  || s_q.a1.kind == ips_pkg::K_STORE);
  assign mem_rd = s_q.a1.v && s_q.a1.kind == ips_pkg::K_LOAD;
  assign fault  = memop && phys >= mem_limit;
  // an older store still in flight to the same word must land first
  assign haz    = (stores(s_q.a2) && s_q.a2.addr == phys)
                  || (stores(s_q.ex) && s_q.ex.addr == phys);
  assign rd_req = mem_rd && !fault && !haz && !wb_block && !s_q.held
                  && (!s_q.a1.fp || fp_ready);
  // load answer is a one-cycle pulse: keep it until the op moves on
  assign rd_have = rd_ack || s_q.held;
  assign rd_val  = s_q.held ? s_q.hdat : rd_data;

  // a process, not an assign: fwd reads pipeline state that is no argument
  always_comb begin
    opnd = mem_rd ? rd_val : fwd(s_q.a1.rs);
  end

  assign fp_valid = s_q.a1.v && s_q.a1.fp && !fault
                    && (!mem_rd || rd_have);
  assign fp_data  = {s_q.a1.raw, opnd};
  assign a2_block = s_q.a1.v && !fault
                    && ((mem_rd && !rd_have) || (s_q.a1.fp && !fp_ready));

  always_comb begin
    a2n      = s_q.a1;
    // float ops leave the integer pipe here
    a2n.v    = s_q.a1.v && !fault && !s_q.a1.fp;
    a2n.addr = phys;
    a2n.a    = fwd(s_q.a1.rd);
    a2n.b    = opnd;
  end

  // execute: micro-word picks the operation
  assign uw_ex = ips_pkg::UCODE[{s_q.a2.kind, s_q.a2.fn}];

  always_comb begin
    unique case (uw_ex[2:0])
      ips_pkg::ALU_ADD: ex_res = s_q.a2.a + s_q.a2.b;
      ips_pkg::ALU_SUB: ex_res = s_q.a2.a - s_q.a2.b;
      ips_pkg::ALU_AND: ex_res = s_q.a2.a & s_q.a2.b;
      ips_pkg::ALU_XOR: ex_res = s_q.a2.a ^ s_q.a2.b;
      ips_pkg::ALU_PB:  ex_res = s_q.a2.b;
      ips_pkg::ALU_PA:  ex_res = s_q.a2.a;
      default:          ex_res = s_q.a2.a;
    endcase
  end

  always_comb begin
    exn   = s_q.a2;
    exn.a = ex_res;
    exn.b = s_q.a2.a;
  end

  // write-back: register update or store handoff
  assign wb_wr    = writes(s_q.ex);
  assign wb_st    = stores(s_q.ex);
  assign wb_block = wb_st && !st_ready;

  ips_lsu #(
    .DEPTH (LSU_DEPTH)
  ) u_lsu (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .st_valid  (wb_st),
    .st_addr   (s_q.ex.addr),
    .st_data   (s_q.ex.b),
    .st_ready  (st_ready),
    .rd_req    (rd_req),
    .rd_addr   (phys),
    .rd_ack    (rd_ack),
    .rd_data   (rd_data),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );

  always_comb begin
    s_d       = s_q;
    s_d.fault = fault && adv;
    s_d.held  = (s_q.held || rd_ack) && !adv;
    if (rd_ack) begin
      s_d.hdat = rd_data;
    end
    if (ic_req && ic_ack) begin
      s_d.fpc = s_q.fpc + 32'(FETCH_BYTES);
    end
    if (taken) begin
      s_d.fpc = target;
      s_d.dpc = target;
    end else if (dec_ok) begin
      s_d.dpc = s_q.dpc + 32'(len);
    end
    // a blocked store freezes every stage after fetch; a waiting load bubbles execute
    if (!wb_block) begin
      if (wb_wr) begin
        s_d.rf[s_q.ex.rd] = s_q.ex.a;
      end
      s_d.ex = exn;
      if (a2_block) begin
        s_d.a2 = '0;
      end else begin
        s_d.a2 = a2n;
        s_d.a1 = a1n;
        s_d.dc = dcn;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q <= '{fpc: ips_pkg::RESET_PC, dpc: ips_pkg::RESET_PC, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign mm_fault = s_q.fault;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_fetch_take;
    ic_req && ic_ack && !taken;
  endsequence

  sequence s_fault_seen;
    fault && adv;
  endsequence

  AST_FETCH_LINE: assert property (s_fetch_take |=>
    int'(qcnt) == int'($past(qcnt)) + FETCH_BYTES - int'($past(pop_len)))
    else $error("fetched line not queued whole");
  AST_REDIRECT: assert property (taken |=>
    ic_addr == $past(target) && qcnt == '0) else $error("branch redirect late");
  AST_QUEUE_MAX: assert property (int'(qcnt) <= QUEUE_BYTES)
    else $error("code queue too full");
  AST_DEC_ONE: assert property (pop_len != 4'h0 |->
    pop_len == {1'b0, win[2:0]} + 4'h1 && qcnt >= CW'(pop_len))
    else $error("decode popped a wrong length");
  AST_IN_ORDER: assert property (adv && s_q.dc.v |=>
    s_q.a1.v && s_q.a1.pc == $past(s_q.dc.pc)) else $error("stage order broken");
  AST_LINEAR: assert property (adv && s_q.dc.v |=>
    s_q.a1.addr == $past(seg_base) + $past(s_q.dc.disp))
    else $error("linear address wrong");
  AST_FP_ROUTE: assert property (fp_valid && fp_ready && !wb_block |=>
    !s_q.a2.v) else $error("float op entered execute");
  AST_EXEC_ADD: assert property (!wb_block && s_q.a2.v
    && uw_ex == ips_pkg::UCODE[0] |=> s_q.ex.a == $past(s_q.a2.a + s_q.a2.b))
    else $error("execute result wrong");
  AST_WB_REG: assert property (wb_wr && !wb_block |=>
    s_q.rf[$past(s_q.ex.rd)] == $past(s_q.ex.a)) else $error("register not written");
  AST_FP_HANDOFF: assert property (fp_valid && fp_ready |->
    !a2_block && fp_data[63:32] == s_q.a1.raw) else $error("float handoff stalled");
  AST_FAULT: assert property (s_fault_seen |=> mm_fault)
    else $error("limit fault not flagged");
  AST_FETCH_STOP: assert property (
    int'(qcnt) > QUEUE_BYTES - FETCH_BYTES |-> !ic_req)
    else $error("fetch without queue room");
endmodule // ips_seq
`default_nettype wire

// File: sim/ips_far.sv
// far-side model: code cache, float unit and external memory
`timescale 1ns/1ps
`default_nettype none
module ips_far (
  // clock
  input  wire logic         clk_sys,
  // code cache
  input  wire logic         ic_req,
  input  wire logic [31:0]  ic_addr,
  output logic              ic_ack,
  output logic [127:0]      ic_data,
  // float unit
  input  wire logic         fp_valid,
  output logic              fp_ready,
  input  wire logic [63:0]  fp_data,
  // external memory
  input  wire logic         mem_req,
  input  wire logic         mem_we,
  input  wire logic [31:0]  mem_addr,
  input  wire logic [31:0]  mem_wdata,
  output logic              mem_ack,
  output logic [31:0]       mem_rdata
);
  logic [7:0]  code [0:255];
  logic [31:0] mem [logic [31:0]];
  logic        lg_we [$];
  logic [31:0] lg_addr [$];
  logic [31:0] lg_data [$];
  logic [63:0] fp_log [$];
  int          mem_lat = 0;
  int          wait_n  = 0;
  logic        fp_slow = 1'b0;
  logic        tick    = 1'b0;

  // cache always answers at once; data follows the address
  assign ic_ack = 1'b1;
  always_comb begin
    for (int i = 0; i < 16; i++) ic_data[i*8 +: 8] = code[8'(ic_addr + 32'(i))];
  end

  // untouched memory words are a pattern of their address
  function automatic logic [31:0] word(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'h5A5A_0000;
  endfunction

  initial begin
    fp_ready  = 1'b1;
    mem_ack   = 1'b0;
    mem_rdata = 32'h0000_0000;
  end

  always @(posedge clk_sys) begin
    tick      <= ~tick;
    fp_ready  <= fp_slow ? tick : 1'b1;
    if (fp_valid === 1'b1 && fp_ready) fp_log.push_back(fp_data);
    mem_ack   <= 1'b0;
    // idle read data keeps moving so a late sample shows up
    mem_rdata <= ~mem_rdata;
    if (mem_req === 1'b1 && !mem_ack) begin
      if (wait_n < mem_lat) begin
        wait_n <= wait_n + 1;
      end else begin
        wait_n    <= 0;
        mem_ack   <= 1'b1;
        mem_rdata <= word(mem_addr);
        lg_we.push_back(mem_we);
        lg_addr.push_back(mem_addr);
        lg_data.push_back(mem_we ? mem_wdata : word(mem_addr));
        if (mem_we) mem[mem_addr] = mem_wdata;
      end
    end
  end
endmodule // ips_far
`default_nettype wire

// File: sim/ips_seq_tb.sv
// self-checking bench for the integer pipeline sequencer
`timescale 1ns/1ps
`default_nettype none
module ips_seq_tb;
  logic         clk_sys   = 1'b0;
  logic         sys_rst   = 1'b1;
  logic [31:0]  seg_base  = 32'h0000_0100;
  logic [31:0]  xlat_base = 32'h0000_1000;
  logic [31:0]  mem_limit = 32'h0000_8000;
  logic         ic_req, ic_ack, mm_fault, fp_valid, fp_ready;
  logic         mem_req, mem_we, mem_ack;
  logic [31:0]  ic_addr, mem_addr, mem_wdata, mem_rdata;
  logic [127:0] ic_data;
  logic [63:0]  fp_data;
  int           bad_count   = 0;
  int           checks_done = 0;
  int           faults      = 0;
  int           acks        = 0;
  int           pc          = 0;

  ips_seq u_ips_seq (.clk_sys(clk_sys), .sys_rst(sys_rst), .ic_req(ic_req),
    .ic_addr(ic_addr), .ic_ack(ic_ack), .ic_data(ic_data), .seg_base(seg_base),
    .xlat_base(xlat_base), .mem_limit(mem_limit), .mm_fault(mm_fault),
    .fp_valid(fp_valid), .fp_ready(fp_ready), .fp_data(fp_data), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  ips_far u_ips_far (.clk_sys(clk_sys), .ic_req(ic_req), .ic_addr(ic_addr),
    .ic_ack(ic_ack), .ic_data(ic_data), .fp_valid(fp_valid), .fp_ready(fp_ready),
    .fp_data(fp_data), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (mm_fault === 1'b1) faults <= faults + 1;
    if (ic_req === 1'b1 && ic_ack === 1'b1) acks <= acks + 1;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask

  function automatic logic [31:0] pa(input logic [31:0] d);
    return seg_base + d + xlat_base;
  endfunction

  function automatic logic [31:0] wd(input logic [31:0] d);
    return pa(d) ^ 32'h5A5A_0000;
  endfunction

  // index of the k-th access of one direction, -1 if absent
  function automatic int nth(input int k, input logic we);
    int c = 0;
    foreach (u_ips_far.lg_we[i]) begin
      if (u_ips_far.lg_we[i] == we) begin
        if (c == k) return i;
        c++;
      end
    end
    return -1;
  endfunction

  task automatic chk_acc(input int k, input logic we, input logic [31:0] d,
                         input logic [31:0] v);
    int i;
    i = nth(k, we);
    if (i < 0) check(64'h0, {pa(d), v});
    else check({u_ips_far.lg_addr[i], u_ips_far.lg_data[i]}, {pa(d), v});
  endtask

  task automatic put(input logic [1:0] k, input logic f, input logic c, input logic [1:0] fn,
                     input logic [2:0] rd, input logic [2:0] rs, input logic [31:0] d);
    int n;
    n = (k == 2'h0) ? 2 : (k == 2'h3) ? 3 : 6;
    u_ips_far.code[pc]   = {k, f, c, 1'b0, 3'(n - 1)};
    u_ips_far.code[pc+1] = {fn, rd, rs};
    for (int i = 2; i < n; i++) u_ips_far.code[pc+i] = d[(i-2)*8 +: 8];
    pc += n;
  endtask

  // hold reset, blank the program image and clear the logs
  task automatic start(input int lat, input logic slow);
    sys_rst = 1'b1;
    for (int i = 0; i < 256; i++) u_ips_far.code[i] = 8'h00;
    u_ips_far.lg_we.delete();
    u_ips_far.lg_addr.delete();
    u_ips_far.lg_data.delete();
    u_ips_far.fp_log.delete();
    u_ips_far.mem.delete();
    u_ips_far.mem_lat = lat;
    u_ips_far.fp_slow = slow;
    pc = 0;
  endtask

  task automatic go;
    put(2'h3, 1'b0, 1'b0, 2'h0, 3'h0, 3'h0, 32'h0000_00FD);
    tick(10);
    sys_rst = 1'b0;
    faults  = 0;
  endtask

  task automatic wait_wr(input int n);
    int t;
    for (t = 0; t < 3000 && nth(n - 1, 1'b1) < 0; t++) tick(1);
    if (t == 3000) begin
      bad_count++;
      $display("ERROR t=%0t store wait ran out", $time);
      finish_test();
    end
    tick(8);
  endtask

  task automatic t_alu;
    logic [31:0] a, b, r;
    start(0, 1'b0);
    put(2'h1, 1'b0, 1'b0, 2'h0, 3'h2, 3'h0, 32'h0000_0010);
    for (int f = 0; f < 4; f++) begin
      put(2'h1, 1'b0, 1'b0, 2'h0, 3'h3, 3'h0, 32'h0000_0014);
      put(2'h0, 1'b0, 1'b0, 2'(f), 3'h3, 3'h2, 32'h0);
      put(2'h2, 1'b0, 1'b0, 2'h0, 3'h3, 3'h0, 32'h0000_0040 + 32'(4 * f));
    end
    go();
    wait_wr(4);
    a = wd(32'h0000_0010);
    b = wd(32'h0000_0014);
    chk_acc(0, 1'b0, 32'h0000_0010, a);
    for (int f = 0; f < 4; f++) begin
      r = (f == 0) ? b + a : (f == 1) ? b - a : (f == 2) ? (b & a) : (b ^ a);
      chk_acc(f, 1'b1, 32'h0000_0040 + 32'(4 * f), r);
    end
    check(64'(u_ips_far.lg_we.size()), 64'h9);
  endtask

  task automatic t_order;
    start(20, 1'b0);
    put(2'h1, 1'b0, 1'b0, 2'h0, 3'h1, 3'h0, 32'h0000_0010);
    for (int i = 0; i < 3; i++) put(2'h2, 1'b0, 1'b0, 2'h0, 3'h1, 3'h0, 32'h50 + 32'(4 * i));
    put(2'h1, 1'b0, 1'b0, 2'h0, 3'h4, 3'h0, 32'h0000_0014);
    put(2'h1, 1'b0, 1'b0, 2'h0, 3'h5, 3'h0, 32'h0000_0058);
    put(2'h2, 1'b0, 1'b0, 2'h0, 3'h4, 3'h0, 32'h0000_005C);
    put(2'h2, 1'b0, 1'b0, 2'h0, 3'h5, 3'h0, 32'h0000_0060);
    go();
    wait_wr(5);
    chk_acc(1, 1'b0, 32'h0000_0014, wd(32'h0000_0014));
    check(64'(nth(1, 1'b0) < nth(1, 1'b1)), 64'h1);
    check(64'(nth(2, 1'b0)), 64'hFFFF_FFFF_FFFF_FFFF);
    chk_acc(3, 1'b1, 32'h0000_005C, wd(32'h0000_0014));
    chk_acc(4, 1'b1, 32'h0000_0060, wd(32'h0000_0010));
  endtask

  task automatic t_float;
    start(0, 1'b1);
    put(2'h1, 1'b0, 1'b0, 2'h0, 3'h2, 3'h0, 32'h0000_0014);
    put(2'h0, 1'b1, 1'b0, 2'h0, 3'h7, 3'h2, 32'h0);
    put(2'h1, 1'b1, 1'b0, 2'h0, 3'h7, 3'h0, 32'h0000_0010);
    // lands past the memory limit, so it must fault and vanish
    put(2'h1, 1'b1, 1'b0, 2'h0, 3'h7, 3'h0, 32'h0000_7000);
    put(2'h2, 1'b0, 1'b0, 2'h0, 3'h2, 3'h0, 32'h0000_0070);
    go();
    wait_wr(1);
    check(64'(u_ips_far.fp_log.size()), 64'h2);
    check(64'(u_ips_far.fp_log[0][31:0]), 64'(wd(32'h0000_0014)));
    check(64'(u_ips_far.fp_log[1][47:0]), {16'h3865, wd(32'h0000_0010)});
    check(64'(faults), 64'h1);
    check(64'(nth(2, 1'b0)), 64'hFFFF_FFFF_FFFF_FFFF);
    chk_acc(0, 1'b1, 32'h0000_0070, wd(32'h0000_0014));
  endtask

  task automatic t_branch;
    start(0, 1'b0);
    put(2'h3, 1'b0, 1'b0, 2'h0, 3'h0, 3'h0, 32'h0000_0006);
    put(2'h2, 1'b0, 1'b0, 2'h0, 3'h0, 3'h0, 32'h0000_0080);
    put(2'h2, 1'b0, 1'b0, 2'h0, 3'h0, 3'h0, 32'h0000_0084);
    put(2'h3, 1'b0, 1'b1, 2'h0, 3'h0, 3'h0, 32'h0000_0006);
    put(2'h2, 1'b0, 1'b0, 2'h0, 3'h0, 3'h0, 32'h0000_0088);
    go();
    wait_wr(2);
    chk_acc(0, 1'b1, 32'h0000_0084, 32'h0000_0000);
    chk_acc(1, 1'b1, 32'h0000_0088, 32'h0000_0000);
    check(64'(u_ips_far.lg_we.size()), 64'h2);
  endtask

  task automatic t_queue;
    int   n;
    logic low;
    low = 1'b0;
    start(150, 1'b0);
    put(2'h1, 1'b0, 1'b0, 2'h0, 3'h1, 3'h0, 32'h0000_0010);
    pc += 64;
    put(2'h2, 1'b0, 1'b0, 2'h0, 3'h1, 3'h0, 32'h0000_0090);
    go();
    // the load stalls decode well past this window
    tick(80);
    n = acks;
    for (int i = 0; i < 60; i++) begin
      tick(1);
      if (ic_req === 1'b0) low = 1'b1;
    end
    check(64'(acks - n), 64'h0);
    check(64'(low), 64'h1);
    wait_wr(1);
    chk_acc(0, 1'b1, 32'h0000_0090, wd(32'h0000_0010));
  endtask

  initial begin
    t_alu();
    t_order();
    t_float();
    t_branch();
    t_queue();
    finish_test();
  end
endmodule // ips_seq_tb
`default_nettype wire
